// ==== spi_flash_image_loader.sv ====
// Notes on behaviour
// - Reset with golden-select low enables master port
// - Controller reads flash bitstream, feeds programming
// - Polarity sets idle clock; phase picks sample edge
// - Select high idle, low across whole transfer
// - Blank device uses polarity and phase one
// - Blank device recovers from serial flash port
// - Auto update only for newer update image
// - Power failure recovers from golden image
// - Back-level protection needs version above back-level
// - Bypass lets golden image program regardless
// - No bypass, old golden image: halt
// - Golden address offset 0, version offset 4
// - Update address offset 6, version offset 10
// - Programming request makes controller program from flash
// - Serial images never change security settings
`timescale 1ns/100ps
`default_nettype none
module spi_flash_image_loader #(
    parameter int IMAGE_BYTES = 1024
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic device_reset_n,
    input wire logic golden_select_n,
    input wire logic spi_miso,
    output logic spi_sck,
    output logic spi_mosi,
    output logic spi_cs_n,
    output logic spi_oe,
    input wire logic iap_request,
    input wire logic device_blank,
    input wire logic clock_polarity_setting,
    input wire logic clock_phase_setting,
    input wire logic recovery_enable,
    input wire logic auto_update_enable,
    input wire logic power_fail_seen,
    input wire logic backlevel_protect,
    input wire logic backlevel_bypass,
    input wire logic [15:0] backlevel_value,
    input wire logic [15:0] design_version,
    output logic [7:0] prog_data,
    output logic prog_valid,
    input wire logic prog_ready,
    output logic prog_golden,
    output logic busy,
    output logic done,
    output logic halted,
    output logic rejected,
    output logic recovery_source_spi,
    output logic security_update_en
);
    // Refuse image sizes the byte counter cannot hold
    if (IMAGE_BYTES < 1 || IMAGE_BYTES > 16777215) begin : g_bad_size
        $error("IMAGE_BYTES out of range");
    end
    localparam logic [23:0] IMG_LAST = 24'(IMAGE_BYTES - 1);

    // Pin synchronisers: miso, strap, device reset
    logic [2:0] sync1;
    logic [2:0] sync2;
    wire miso_s = sync2[0];
    wire golden_sel_n_s = sync2[1];
    wire dev_rst_n_s = sync2[2];
    logic dev_prev; // Last synchronised device reset level

    // Loader state
    spi_loader_pkg::loader_state_t state;
    spi_loader_pkg::loader_state_t next_state;
    logic [23:0] cnt; // Byte index within the current phase
    logic [23:0] next_cnt;
    logic [95:0] dir; // Directory bytes, first byte highest
    logic start_pending; // Power-on or device reset seen
    logic [1:0] settle; // Strap settling count
    logic auto_mode; // Started by reset rather than request
    logic inflight; // A byte exchange is running
    logic sh_start;
    logic [7:0] sh_tx;
    logic golden_sel; // Image chosen is the golden one
    // Two-entry buffer toward the programming engine
    logic [7:0] spare_data;
    logic spare_valid;

    // Shifter outputs
    wire sh_busy;
    wire sh_done;
    wire [7:0] sh_rx;

    // Blank devices run mode 3
    wire cpol_eff = device_blank ? spi_loader_pkg::BLANK_POLARITY : clock_polarity_setting;
    wire cpha_eff = device_blank ? spi_loader_pkg::BLANK_PHASE : clock_phase_setting;

    // Directory fields, most significant byte first
    wire [31:0] golden_addr = dir[95-8*spi_loader_pkg::GOLD_ADDR_OFS -: 32];
    wire [15:0] golden_version = dir[95-8*spi_loader_pkg::GOLD_VER_OFS -: 16];
    wire [31:0] update_addr = dir[95-8*spi_loader_pkg::UPD_ADDR_OFS -: 32];
    wire [15:0] update_version = dir[95-8*spi_loader_pkg::UPD_VER_OFS -: 16];

    // Image choice, unsigned compares
    wire recover = recovery_enable && power_fail_seen;
    wire golden_ok = !backlevel_protect || backlevel_bypass
        || (golden_version > backlevel_value);
    wire update_bl_ok = !backlevel_protect || (update_version > backlevel_value);
    wire update_newer = update_version > design_version;
    wire take_golden = recover && golden_ok;
    wire halt_now = recover && !golden_ok;
    wire take_update = !recover && update_bl_ok
        && (!(auto_mode && auto_update_enable) || update_newer);

    // Start decode
    wire dev_fall = dev_prev && !dev_rst_n_s;
    wire boot_go = start_pending && (settle == spi_loader_pkg::SETTLE_LAST)
        && !golden_sel_n_s;
    wire iap_go = iap_request && !start_pending;
    wire idle = (state == spi_loader_pkg::ST_IDLE) || (state == spi_loader_pkg::ST_DONE)
        || (state == spi_loader_pkg::ST_HALT);

    // Byte traffic decode
    wire in_hdr = (state == spi_loader_pkg::ST_DIR_HDR) || (state == spi_loader_pkg::ST_IMG_HDR);
    wire in_img = state == spi_loader_pkg::ST_IMG_DATA;
    wire want_byte = in_hdr || (state == spi_loader_pkg::ST_DIR_DATA) || (in_img && !spare_valid);
    wire issue = want_byte && !inflight && !sh_busy;
    wire byte_done = sh_done && inflight;
    wire push = byte_done && in_img;
    wire pop = prog_valid && prog_ready;
    wire [23:0] rd_addr = (state == spi_loader_pkg::ST_DIR_HDR) ? spi_loader_pkg::DIR_ADDR
        : (golden_sel ? golden_addr[23:0] : update_addr[23:0]);
    wire [7:0] hdr_byte = (cnt[1:0] == 2'h0) ? spi_loader_pkg::CMD_READ
        : (cnt[1:0] == 2'h1) ? rd_addr[23:16]
        : (cnt[1:0] == 2'h2) ? rd_addr[15:8] : rd_addr[7:0];
    wire [7:0] next_tx = in_hdr ? hdr_byte : 8'h00;
    wire active_next = (next_state != spi_loader_pkg::ST_IDLE)
        && (next_state != spi_loader_pkg::ST_DONE) && (next_state != spi_loader_pkg::ST_HALT);
    wire select_next = (next_state == spi_loader_pkg::ST_DIR_HDR)
        || (next_state == spi_loader_pkg::ST_DIR_DATA)
        || (next_state == spi_loader_pkg::ST_IMG_HDR)
        || (next_state == spi_loader_pkg::ST_IMG_DATA);

    // Next state and byte index
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        if (dev_fall) begin
            next_state = spi_loader_pkg::ST_IDLE;
            next_cnt = 24'h000000;
        end else begin
            case (state)
                spi_loader_pkg::ST_IDLE, spi_loader_pkg::ST_DONE, spi_loader_pkg::ST_HALT: begin
                    // Directory read always starts at flash address zero
                    if (boot_go || iap_go) begin
                        next_state = spi_loader_pkg::ST_DIR_HDR;
                        next_cnt = 24'h000000;
                    end
                end
                spi_loader_pkg::ST_DIR_HDR, spi_loader_pkg::ST_IMG_HDR: begin
                    if (byte_done) begin
                        next_cnt = (cnt[1:0] == spi_loader_pkg::HDR_LAST) ? 24'h000000
                            : cnt + 24'h000001;
                        if (cnt[1:0] == spi_loader_pkg::HDR_LAST) begin
                            next_state = (state == spi_loader_pkg::ST_DIR_HDR)
                                ? spi_loader_pkg::ST_DIR_DATA : spi_loader_pkg::ST_IMG_DATA;
                        end
                    end
                end
                spi_loader_pkg::ST_DIR_DATA: begin
                    if (byte_done) begin
                        next_cnt = cnt + 24'h000001;
                        if (cnt[3:0] == spi_loader_pkg::DIR_LAST) begin
                            next_state = spi_loader_pkg::ST_DECIDE;
                        end
                    end
                end
                spi_loader_pkg::ST_DECIDE: begin
                    // Select drops here between the two reads
                    next_cnt = 24'h000000;
                    if (halt_now) begin
                        next_state = spi_loader_pkg::ST_HALT;
                    end else if (take_golden || take_update) begin
                        next_state = spi_loader_pkg::ST_IMG_HDR;
                    end else begin
                        next_state = spi_loader_pkg::ST_DONE;
                    end
                end
                spi_loader_pkg::ST_IMG_DATA: begin
                    if (byte_done) begin
                        next_cnt = cnt + 24'h000001;
                        if (cnt == IMG_LAST) begin
                            next_state = spi_loader_pkg::ST_DONE;
                        end
                    end
                end
                default: begin
                    next_state = spi_loader_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Synchronisers and device reset edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            dev_prev <= 1'b1;
        end else begin
            sync1 <= {device_reset_n, golden_select_n, spi_miso};
            sync2 <= sync1;
            dev_prev <= dev_rst_n_s;
        end
    end

    // Start bookkeeping; power-on counts as a reset event
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_pending <= 1'b1;
            settle <= 2'h0;
            auto_mode <= 1'b0;
        end else begin
            settle <= dev_fall ? 2'h0
                : ((settle == spi_loader_pkg::SETTLE_LAST) ? settle : settle + 2'h1);
            if (dev_fall) begin
                start_pending <= 1'b1;
            end else if (idle && settle == spi_loader_pkg::SETTLE_LAST) begin
                start_pending <= 1'b0;
            end
            if (idle && (boot_go || iap_go)) begin
                auto_mode <= boot_go;
            end
        end
    end

    // State, counter, directory and image choice
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= spi_loader_pkg::ST_IDLE;
            cnt <= 24'h000000;
            dir <= '0;
            golden_sel <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            if (byte_done && state == spi_loader_pkg::ST_DIR_DATA) begin
                dir <= {dir[87:0], sh_rx};
            end
            if (state == spi_loader_pkg::ST_DECIDE) begin
                golden_sel <= take_golden;
            end
        end
    end

    // Byte issue toward the shifter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inflight <= 1'b0;
            sh_start <= 1'b0;
            sh_tx <= 8'h00;
        end else begin
            inflight <= issue || (inflight && !sh_done);
            sh_start <= issue;
            sh_tx <= issue ? next_tx : sh_tx;
        end
    end

    // Rejection sticks through the finished state
    wire rejected_next = (state == spi_loader_pkg::ST_DECIDE)
        ? (!halt_now && !take_golden && !take_update)
        : ((next_state == spi_loader_pkg::ST_DONE) && rejected);

    // Pin and status outputs, all registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spi_cs_n <= 1'b1;
            spi_oe <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            halted <= 1'b0;
            rejected <= 1'b0;
            prog_golden <= 1'b0;
            recovery_source_spi <= 1'b1;
            security_update_en <= 1'b0;
        end else begin
            spi_cs_n <= !select_next;
            spi_oe <= active_next;
            busy <= active_next;
            done <= (next_state == spi_loader_pkg::ST_DONE) && !rejected_next;
            halted <= next_state == spi_loader_pkg::ST_HALT;
            rejected <= rejected_next;
            // Held through the finished state so buffered last bytes keep their tag
            prog_golden <= (next_state == spi_loader_pkg::ST_IMG_DATA) ? golden_sel
                : (prog_golden && (next_state == spi_loader_pkg::ST_DONE));
            recovery_source_spi <= 1'b1;
            security_update_en <= 1'b0;
        end
    end
    // Two-entry buffer; a stall holds the next byte exchange
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_valid <= 1'b0;
            prog_data <= 8'h00;
            spare_valid <= 1'b0;
            spare_data <= 8'h00;
        end else if (!prog_valid || pop) begin
            prog_valid <= spare_valid || push;
            prog_data <= spare_valid ? spare_data : sh_rx;
            spare_valid <= spare_valid && push;
            spare_data <= sh_rx;
        end else if (push) begin
            spare_valid <= 1'b1;
            spare_data <= sh_rx;
        end
    end

    // Byte exchange engine
    spi_byte_shifter #(
        .HALF(spi_loader_pkg::SCK_HALF_CYCLES)
    ) u_shifter (
        .clk(clk),
        .rst_b(rst_b),
        .cpol(cpol_eff),
        .cpha(cpha_eff),
        .start(sh_start),
        .tx_byte(sh_tx),
        .miso(miso_s),
        .sck(spi_sck),
        .mosi(spi_mosi),
        .busy(sh_busy),
        .done(sh_done),
        .rx_byte(sh_rx)
    );

    // Checks
    sequence decide_recover;
        state == spi_loader_pkg::ST_DECIDE && recover;
    endsequence
    sequence byte_into_buffer;
        push && !spare_valid;
    endsequence
    boot_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        (idle && boot_go && !dev_fall) |=> (spi_oe && state == spi_loader_pkg::ST_DIR_HDR))
        else $error("boot start did not enable master port");
    stream_out_a: assert property (@(posedge clk) disable iff (!rst_b)
        byte_into_buffer |-> ##1 prog_valid)
        else $error("received image byte not offered");
    cs_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state == spi_loader_pkg::ST_IDLE) |-> spi_cs_n)
        else $error("select active while idle");
    cs_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (in_img && $past(in_img)) |-> !spi_cs_n)
        else $error("select dropped inside image");
    blank_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        (device_blank && !sh_busy && !$past(sh_busy) && $past(device_blank)) |-> spi_sck)
        else $error("blank device idle clock not high");
    recov_src_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 recovery_source_spi)
        else $error("recovery source left serial port");
    newer_only_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state == spi_loader_pkg::ST_DECIDE && !recover && auto_mode && auto_update_enable
        && !update_newer && !dev_fall) |=> state == spi_loader_pkg::ST_DONE)
        else $error("older update image accepted");
    golden_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
        (decide_recover and golden_ok && !dev_fall) |=> (state == spi_loader_pkg::ST_IMG_HDR)
        ##1 golden_sel)
        else $error("golden image not chosen on recovery");
    backlevel_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state == spi_loader_pkg::ST_DECIDE && !recover && backlevel_protect
        && update_version <= backlevel_value) |=> state != spi_loader_pkg::ST_IMG_HDR)
        else $error("back-level image accepted");
    bypass_a: assert property (@(posedge clk) disable iff (!rst_b)
        (decide_recover and backlevel_bypass && !dev_fall) |=> state == spi_loader_pkg::ST_IMG_HDR)
        else $error("bypass did not allow golden image");
    recov_halt_a: assert property (@(posedge clk) disable iff (!rst_b)
        (decide_recover and backlevel_protect && !backlevel_bypass
        && golden_version <= backlevel_value && !dev_fall) |=> halted [*2])
        else $error("recovery did not halt");
    no_security_a: assert property (@(posedge clk) disable iff (!rst_b)
        busy |-> !security_update_en)
        else $error("security update enabled");
endmodule : spi_flash_image_loader
`default_nettype wire

// ==== spi_loader_pkg.sv ====
package spi_loader_pkg;
    // Timing of the serial clock
    localparam int CLK_PERIOD_NS = 10; // System clock period
    localparam int SCK_HALF_NS = 40; // Least half period of the serial clock
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Flash read command and directory location
    localparam logic [7:0] CMD_READ = 8'h03; // Plain serial read
    localparam logic [23:0] DIR_ADDR = 24'h000000; // Directory base in flash
    localparam logic [1:0] HDR_LAST = 2'h3; // Command plus three address bytes
    localparam logic [3:0] DIR_LAST = 4'hb; // Directory is twelve bytes
    // Directory field byte offsets, most significant byte first
    localparam int GOLD_ADDR_OFS = 0;
    localparam int GOLD_VER_OFS = 4;
    localparam int UPD_ADDR_OFS = 6;
    localparam int UPD_VER_OFS = 10;
    // Blank-device defaults of the serial mode
    localparam logic BLANK_POLARITY = 1'h1;
    localparam logic BLANK_PHASE = 1'h1;
    // Settle cycles before the golden-select strap is trusted
    localparam logic [1:0] SETTLE_LAST = 2'h3;
    // Loader states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DIR_HDR = 3'b001,
        ST_DIR_DATA = 3'b010,
        ST_DECIDE = 3'b011,
        ST_IMG_HDR = 3'b100,
        ST_IMG_DATA = 3'b101,
        ST_DONE = 3'b110,
        ST_HALT = 3'b111
    } loader_state_t;
endpackage : spi_loader_pkg

// ==== spi_byte_shifter.sv ====
`timescale 1ns/100ps
`default_nettype none
// One-byte serial exchange in any of the four clock modes
module spi_byte_shifter #(
    parameter int HALF = spi_loader_pkg::SCK_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic miso,
    output logic sck,
    output logic mosi,
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte
);
    localparam int CW = $clog2(HALF + 1);
    // Refuse a half period the edge logic cannot serve
    if (HALF < 2) begin : g_bad_half
        $error("HALF must be at least 2");
    end
    logic [CW-1:0] half_cnt; // Cycles into the current half period
    logic [4:0] edge_cnt; // Clock edges already made
    logic [7:0] tx; // Bits still to send
    logic [7:0] rx; // Bits received so far
    // Edge decode
    wire tick = busy && (half_cnt == CW'(HALF - 1));
    wire leading = ~edge_cnt[0]; // Next edge leaves the idle level
    wire sample_now = tick && (leading ^ cpha); // Phase 0 samples leading
    wire shift_now = tick && !(leading ^ cpha); // Phase 1 shifts leading
    wire last = tick && (edge_cnt == 5'h0f);
    wire [7:0] rx_next = {rx[6:0], miso};
    // Shift engine; sixteen toggles return the clock to idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            done <= 1'b0;
            sck <= 1'b1;
            mosi <= 1'b0;
            half_cnt <= '0;
            edge_cnt <= 5'h00;
            tx <= 8'h00;
            rx <= 8'h00;
            rx_byte <= 8'h00;
        end else begin
            done <= last;
            if (start && !busy) begin
                // Phase 0 must present the first bit before the first edge
                busy <= 1'b1;
                half_cnt <= '0;
                edge_cnt <= 5'h00;
                sck <= cpol;
                mosi <= cpha ? mosi : tx_byte[7];
                tx <= cpha ? tx_byte : {tx_byte[6:0], 1'b0};
            end else if (busy) begin
                half_cnt <= tick ? '0 : half_cnt + CW'(1);
                if (tick) begin
                    sck <= ~sck;
                    edge_cnt <= edge_cnt + 5'h01;
                end
                if (sample_now) begin
                    rx <= rx_next;
                end
                if (shift_now) begin
                    mosi <= tx[7];
                    tx <= {tx[6:0], 1'b0};
                end
                if (last) begin
                    busy <= 1'b0;
                    rx_byte <= sample_now ? rx_next : rx;
                end
            end else begin
                // Idle level follows polarity
                sck <= cpol;
            end
        end
    end
endmodule : spi_byte_shifter
`default_nettype wire

// ==== flash_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Serial flash: directory at byte zero, address pattern above it
module flash_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic cs_n,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [95:0] dir,
    output logic miso
);
    int cnt; // Sample edges in frame
    logic [31:0] hdr; // Command and address
    logic [23:0] a; // Byte being sent
    logic [7:0] b; // Its content
    // Byte content by address
    function automatic logic [7:0] mem(input logic [23:0] x);
        if (x < 24'h00000c) begin
            return dir[95 - 8 * x -: 8];
        end
        return x[7:0] ^ 8'hc3;
    endfunction : mem
    initial begin
        cnt = 0;
        miso = 1'b0;
    end
    // New frame; released line shows inverse of last bit
    always @(negedge cs_n) cnt = 0;
    always @(posedge cs_n) miso = ~miso;
    // Sample edge takes header, shift edge drives data MSB first
    always @(sck) begin
        if (!cs_n && (sck == (cpol == cpha))) begin
            // Only the header is kept; filler bits must not move the address
            if (cnt < 32) begin
                hdr = {hdr[30:0], mosi};
            end
            cnt = cnt + 1;
        end else if (!cs_n && cnt >= 32) begin
            a = hdr[23:0] + 24'((cnt - 32) / 8);
            b = mem(a);
            miso = b[7 - (cnt - 32) % 8];
        end
    end
endmodule : flash_model
`default_nettype wire

// ==== tb_spi_flash_image_loader.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_spi_flash_image_loader;
    localparam int NB = 16; // Image length under test
    logic clk, rst_b, device_reset_n, golden_select_n, spi_miso, spi_sck, spi_mosi;
    logic spi_cs_n, spi_oe, iap_request, device_blank, clock_polarity_setting;
    logic clock_phase_setting, recovery_enable, auto_update_enable, power_fail_seen;
    logic backlevel_protect, backlevel_bypass, prog_valid, prog_ready, prog_golden;
    logic busy, done, halted, rejected, recovery_source_spi, security_update_en;
    logic [15:0] backlevel_value, design_version, gver, uver;
    logic [7:0] prog_data, base;
    logic gold;
    logic [95:0] dir;
    int miscompares, check_count, cycles, taken;
    // Directory: golden at 0x140, update at 0x280
    assign dir = {32'h00000140, gver, 32'h00000280, uver};
    always #5 clk = ~clk;
    spi_flash_image_loader #(.IMAGE_BYTES(NB)) uut (.clk, .rst_b, .device_reset_n,
        .golden_select_n, .spi_miso, .spi_sck, .spi_mosi, .spi_cs_n, .spi_oe, .iap_request,
        .device_blank, .clock_polarity_setting, .clock_phase_setting, .recovery_enable,
        .auto_update_enable, .power_fail_seen, .backlevel_protect, .backlevel_bypass,
        .backlevel_value, .design_version, .prog_data, .prog_valid, .prog_ready,
        .prog_golden, .busy, .done, .halted, .rejected, .recovery_source_spi,
        .security_update_en);
    flash_model fm (.sck(spi_sck), .mosi(spi_mosi), .cs_n(spi_cs_n),
        .cpol(device_blank | clock_polarity_setting),
        .cpha(device_blank | clock_phase_setting), .dir(dir), .miso(spi_miso));
    // Verdict
    task close_out;
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    task cmp(input string w, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask : cmp
    // Hang guard and stalling sink
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            close_out();
        end
        prog_ready <= ~prog_ready;
        if (prog_valid && prog_ready) begin
            cmp("prog_data", (base + 8'(taken)) ^ 8'hc3, prog_data);
            cmp("prog_golden", gold, prog_golden);
            taken++;
        end
    end
    // One load: device reset, optional request, outcome
    task run(input logic boot, input logic [7:0] bs, input logic gd, input int n,
             input logic hl, input logic rj);
        @(posedge clk);
        golden_select_n <= !boot;
        device_reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        cmp("idle sck", device_blank | clock_polarity_setting, spi_sck);
        cmp("idle cs_n", 1, spi_cs_n);
        device_reset_n <= 1'b1;
        base = bs;
        gold = gd;
        taken = 0;
        repeat (12) @(posedge clk);
        cmp("busy", boot, busy);
        cmp("oe", boot, spi_oe);
        iap_request <= !boot;
        @(posedge clk);
        iap_request <= 1'b0;
        for (int i = 0; i < 20000 && !(done === 1'b1 || halted === 1'b1 ||
             rejected === 1'b1); i++) @(posedge clk);
        repeat (2) @(posedge clk);
        cmp("bytes", n, 16'(taken));
        cmp("halted", hl, halted);
        cmp("rejected", rj, rejected);
        cmp("done", !hl && !rj, done);
        cmp("oe idle", 0, spi_oe);
        cmp("cs_n", 1, spi_cs_n);
        cmp("source", 1, recovery_source_spi);
        cmp("security", 0, security_update_en);
    endtask : run
    task t_modes;
        for (int m = 0; m < 4; m++) begin
            clock_polarity_setting <= m[1];
            clock_phase_setting <= m[0];
            run(0, 8'h80, 0, NB, 0, 0);
        end
    endtask : t_modes
    task t_blank;
        device_blank <= 1'b1;
        run(0, 8'h80, 0, NB, 0, 0);
        device_blank <= 1'b0;
    endtask : t_blank
    task t_recovery;
        {recovery_enable, power_fail_seen, backlevel_protect} <= 3'h7;
        gver = 16'h0005;
        run(0, 8'h40, 1, NB, 0, 0);
        gver = 16'h0003;
        backlevel_bypass <= 1'b1;
        run(0, 8'h40, 1, NB, 0, 0);
        backlevel_bypass <= 1'b0;
        run(0, 8'h40, 1, 0, 1, 0);
        {recovery_enable, power_fail_seen} <= 2'h0;
    endtask : t_recovery
    task t_backlevel;
        uver = 16'h0004;
        run(0, 8'h80, 0, 0, 0, 1);
        uver = 16'h8001;
        run(0, 8'h80, 0, NB, 0, 0);
        backlevel_protect <= 1'b0;
    endtask : t_backlevel
    task t_auto;
        auto_update_enable <= 1'b1;
        uver = 16'h0003;
        run(1, 8'h80, 0, 0, 0, 1);
        uver = 16'h0004;
        run(1, 8'h80, 0, NB, 0, 0);
    endtask : t_auto
    initial begin
        {clk, rst_b, device_reset_n, golden_select_n, iap_request} = 5'h06;
        {device_blank, clock_polarity_setting, clock_phase_setting} = 3'h0;
        {recovery_enable, auto_update_enable, power_fail_seen} = 3'h0;
        {backlevel_protect, backlevel_bypass, prog_ready} = 3'h0;
        backlevel_value = 16'h0004;
        design_version = 16'h0003;
        gver = 16'h0005;
        uver = 16'h0005;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_modes();
        t_blank();
        t_recovery();
        t_backlevel();
        t_auto();
        close_out();
    end
endmodule : tb_spi_flash_image_loader
`default_nettype wire
